// ### src/sps_sleep_seq.sv
// Purpose: Sleep sequencer that powers down or resets a host until a wake.
// Assumes: irq_req_i comes from logic on clock_i; power_valid_i is a pin.
// Notes: AHB-Lite slave; writes have no wait state, reads one wait state.
//
// Overview of operation
// - Select value 6 routes the sleep state machine onto the switch pin.
// - Select 6 with low-resistance switch: pin low outside sleep, floats asleep.
// - Select 6 without low-resistance switch: pin is an active-high sleep flag.
// - Wake event is the OR of the eight enabled interrupt requests.
// - In run, power on, no host reset after the extension, request clear, slept flag kept.
// - Wait count 1 to 7 enters wait state for that many 8 ms ticks.
// - Wait behaves like run with request set; wake returns to run.
// - Sleep removes power; host reset asserted only if reset-in-sleep set.
// - Slept flag is set on entering sleep.
// - Wake in sleep returns to run, power back, reset released after the extension.
// - Request refused unless counters run and alarm, running countdown, ext1 or ext2 is enabled, or watchdog has a multiplier and no reset.
// - Request refused while an enabled interrupt is pending.
// - Select value 7, the reset value, drives the pin from a static level.
// - Raising the static level is ignored while the lockout bit is set.
// - Request is raised only by a write to the sleep control register.
// - Host reset stays asserted for a fixed extension after leaving sleep.
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module sps_sleep_seq #(
  parameter int TICK_CYCLES = sps_pkg::TICK_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic power_valid_i,
  input wire logic [7:0] irq_req_i,
  output logic power_switch_signal_o,
  output logic host_reset_out_o,
  output logic switch_irq2_pin_o,
  output logic switch_irq2_pin_oe_o,
  output logic low_res_switch_o,
  output logic bus_gate_o
);

  // ************************************************************
  // Power-valid synchroniser
  // ************************************************************
  logic pv_meta_r;
  logic pv_r;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      pv_meta_r <= 1'b0;
      pv_r <= 1'b0;
    end
    else
    begin
      pv_meta_r <= power_valid_i;
      pv_r <= pv_meta_r;
    end
  end

  // ************************************************************
  // AHB-Lite slave
  // ************************************************************
  logic take;
  logic wr_pend_r;
  logic rd_wait_r;
  logic [11:0] addr_r;
  logic [31:0] rd_val;
  logic wr_ctrl;
  logic wr_pin;
  logic wr_wake;

  assign take = hsel_i && hready_i && htrans_i[1];
  assign wr_ctrl = wr_pend_r && (addr_r == sps_pkg::SLEEP_CTRL_OFS);
  assign wr_pin = wr_pend_r && (addr_r == sps_pkg::PIN_CTRL_OFS);
  assign wr_wake = wr_pend_r && (addr_r == sps_pkg::WAKE_CFG_OFS);

  // Reads are answered one cycle late so that a write completing in the
  // same cycle as the read address phase is already visible.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      wr_pend_r <= 1'b0;
      rd_wait_r <= 1'b0;
      addr_r <= 12'h000;
      hreadyout_o <= 1'b1;
      hrdata_o <= 32'h00000000;
      hresp_o <= 1'b0;
    end
    else
    begin
      wr_pend_r <= take && hwrite_i;
      rd_wait_r <= take && !hwrite_i;
      hreadyout_o <= !(take && !hwrite_i);
      hresp_o <= 1'b0;
      if (take)
        addr_r <= haddr_i[11:0];
      if (rd_wait_r)
        hrdata_o <= rd_val;
    end
  end

  // ************************************************************
  // Configuration registers
  // ************************************************************
  logic [2:0] wpc_r;
  logic rsten_r;
  logic gate_r;
  logic [2:0] sel_r;
  logic lowres_r;
  logic level_r;
  logic lock_r;
  logic [7:0] en_r;
  logic cd_run_r;
  logic halt_r;
  logic wdrst_r;
  logic [4:0] mult_r;
  logic level_wr;

  // A rising static level only lands while unlocked; lowering it is free.
  assign level_wr = hwdata_i[sps_pkg::PC_LEVEL_BIT];

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      wpc_r <= sps_pkg::WPC_RST;
      rsten_r <= 1'b0;
      gate_r <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      wpc_r <= hwdata_i[sps_pkg::SC_WPC_LSB +: sps_pkg::WPC_W];
      rsten_r <= hwdata_i[sps_pkg::SC_RSTEN_BIT];
      gate_r <= hwdata_i[sps_pkg::SC_GATE_BIT];
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      sel_r <= sps_pkg::SEL_STATIC;
      lowres_r <= 1'b0;
      level_r <= 1'b0;
      lock_r <= sps_pkg::LOCK_RST;
    end
    else if (wr_pin)
    begin
      sel_r <= hwdata_i[sps_pkg::PC_SEL_LSB +: sps_pkg::SEL_W];
      lowres_r <= hwdata_i[sps_pkg::PC_LOWRES_BIT];
      lock_r <= hwdata_i[sps_pkg::PC_LOCK_BIT];
      if (!(level_wr && !level_r && lock_r))
        level_r <= level_wr;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      en_r <= sps_pkg::EN_RST;
      cd_run_r <= 1'b0;
      halt_r <= 1'b0;
      wdrst_r <= 1'b0;
      mult_r <= 5'h00;
    end
    else if (wr_wake)
    begin
      en_r <= hwdata_i[sps_pkg::WC_EN_LSB +: sps_pkg::NUM_SRC];
      cd_run_r <= hwdata_i[sps_pkg::WC_RUN_BIT];
      halt_r <= hwdata_i[sps_pkg::WC_HALT_BIT];
      wdrst_r <= hwdata_i[sps_pkg::WC_WDRST_BIT];
      mult_r <= hwdata_i[sps_pkg::WC_MULT_LSB +: sps_pkg::MULT_W];
    end
  end

  // ************************************************************
  // Wake qualification and request guard
  // ************************************************************
  sps_pkg::sps_state_type state_r;
  logic wake_event;
  logic wake_source_ok;
  logic accept;
  logic [2:0] wpc_new;
  logic go_sleep;
  logic wait_expired;
  logic [2:0] wcnt_r;
  logic tick;
  logic sleep_request_r;
  logic slept_flag_r;

  assign wake_event = |(irq_req_i & en_r);
  assign wake_source_ok = !halt_r && (en_r[sps_pkg::SRC_ALARM]
    || (en_r[sps_pkg::SRC_COUNTDOWN] && cd_run_r)
    || en_r[sps_pkg::SRC_EXT1] || en_r[sps_pkg::SRC_EXT2]
    || ((mult_r != 5'h00) && !wdrst_r));
  assign wpc_new = hwdata_i[sps_pkg::SC_WPC_LSB +: sps_pkg::WPC_W];
  // A pending enabled interrupt blocks the request as well.
  assign accept = wr_ctrl && hwdata_i[sps_pkg::SC_REQ_BIT] && wake_source_ok
    && !wake_event && pv_r && (state_r == sps_pkg::ST_RUN);
  assign wait_expired = (state_r == sps_pkg::ST_WAIT) && (wcnt_r == 3'h0);
  assign go_sleep = pv_r && ((accept && (wpc_new == 3'h0))
    || ((state_r == sps_pkg::ST_WAIT) && !wake_event && wait_expired));

  sps_tick_div #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .clear_i(accept),
    .tick_o(tick)
  );

  // ************************************************************
  // Sleep state machine
  // ************************************************************
  always_ff @(posedge clock_i)
  begin
    if (rst_i || !pv_r)
    begin
      state_r <= sps_pkg::ST_RUN;
      sleep_request_r <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        sps_pkg::ST_RUN:
        begin
          if (accept)
          begin
            sleep_request_r <= 1'b1;
            state_r <= go_sleep ? sps_pkg::ST_SLEEP : sps_pkg::ST_WAIT;
          end
        end
        sps_pkg::ST_WAIT:
        begin
          if (wake_event)
          begin
            state_r <= sps_pkg::ST_RUN;
            sleep_request_r <= 1'b0;
          end
          else if (wait_expired)
            state_r <= sps_pkg::ST_SLEEP;
        end
        sps_pkg::ST_SLEEP:
        begin
          if (wake_event)
          begin
            state_r <= sps_pkg::ST_RUN;
            sleep_request_r <= 1'b0;
          end
        end
        default:
        begin
          state_r <= sps_pkg::ST_RUN;
          sleep_request_r <= 1'b0;
        end
      endcase
    end
  end

  // The divider restarts on acceptance, so the wait spans exactly the
  // programmed number of ticks, inside the allowed one-tick window.
  always_ff @(posedge clock_i)
  begin
    if (rst_i || !pv_r)
      wcnt_r <= 3'h0;
    else if (accept)
      wcnt_r <= wpc_new;
    else if ((state_r == sps_pkg::ST_WAIT) && tick && (wcnt_r != 3'h0))
      wcnt_r <= wcnt_r - 3'h1;
  end

  // Entry to sleep wins over a clear written in the same cycle.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      slept_flag_r <= 1'b0;
    else if (go_sleep)
      slept_flag_r <= 1'b1;
    else if (wr_ctrl && !hwdata_i[sps_pkg::SC_SLEPT_BIT])
      slept_flag_r <= 1'b0;
  end

  // ************************************************************
  // Host reset extension
  // ************************************************************
  logic [3:0] ext_cnt_r;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      ext_cnt_r <= 4'h0;
    else if ((state_r == sps_pkg::ST_SLEEP) && wake_event && pv_r && rsten_r)
      ext_cnt_r <= sps_pkg::RST_EXT_TICKS;
    else if (tick && (ext_cnt_r != 4'h0))
      ext_cnt_r <= ext_cnt_r - 4'h1;
  end

  // ************************************************************
  // Pin and power outputs
  // ************************************************************
  logic pin_level;

  // Selections other than sleep and static belong to other sources;
  // this block leaves the open-drain pin released for them.
  always_comb
  begin
    unique case (sel_r)
      sps_pkg::SEL_SLEEP: pin_level = (state_r == sps_pkg::ST_SLEEP);
      sps_pkg::SEL_STATIC: pin_level = level_r;
      default: pin_level = 1'b1;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      power_switch_signal_o <= 1'b1;
      host_reset_out_o <= 1'b0;
      switch_irq2_pin_o <= 1'b0;
      switch_irq2_pin_oe_o <= 1'b1;
      low_res_switch_o <= 1'b0;
      bus_gate_o <= 1'b0;
    end
    else
    begin
      power_switch_signal_o <= (state_r != sps_pkg::ST_SLEEP);
      host_reset_out_o <= (rsten_r && (state_r == sps_pkg::ST_SLEEP))
        || (ext_cnt_r != 4'h0);
      switch_irq2_pin_o <= 1'b0;
      switch_irq2_pin_oe_o <= !pin_level;
      low_res_switch_o <= lowres_r && (sel_r == sps_pkg::SEL_SLEEP);
      bus_gate_o <= gate_r && (state_r == sps_pkg::ST_SLEEP);
    end
  end

  // ************************************************************
  // Register read view
  // ************************************************************
  always_comb
  begin
    rd_val = 32'h00000000;
    unique case (addr_r)
      sps_pkg::SLEEP_CTRL_OFS:
      begin
        rd_val[sps_pkg::SC_WPC_LSB +: sps_pkg::WPC_W] = wpc_r;
        rd_val[sps_pkg::SC_SLEPT_BIT] = slept_flag_r;
        rd_val[sps_pkg::SC_GATE_BIT] = gate_r;
        rd_val[sps_pkg::SC_RSTEN_BIT] = rsten_r;
        rd_val[sps_pkg::SC_REQ_BIT] = sleep_request_r;
      end
      sps_pkg::PIN_CTRL_OFS:
      begin
        rd_val[sps_pkg::PC_SEL_LSB +: sps_pkg::SEL_W] = sel_r;
        rd_val[sps_pkg::PC_LOWRES_BIT] = lowres_r;
        rd_val[sps_pkg::PC_LEVEL_BIT] = level_r;
        rd_val[sps_pkg::PC_LOCK_BIT] = lock_r;
      end
      sps_pkg::WAKE_CFG_OFS:
      begin
        rd_val[sps_pkg::WC_EN_LSB +: sps_pkg::NUM_SRC] = en_r;
        rd_val[sps_pkg::WC_RUN_BIT] = cd_run_r;
        rd_val[sps_pkg::WC_HALT_BIT] = halt_r;
        rd_val[sps_pkg::WC_WDRST_BIT] = wdrst_r;
        rd_val[sps_pkg::WC_MULT_LSB +: sps_pkg::MULT_W] = mult_r;
      end
      sps_pkg::STATUS_OFS:
      begin
        rd_val[sps_pkg::NUM_SRC-1:0] = irq_req_i;
        rd_val[sps_pkg::ST_STATE_LSB +: 2] = state_r;
        rd_val[sps_pkg::ST_EXPIRED_BIT] = wait_expired;
        rd_val[sps_pkg::ST_PVALID_BIT] = pv_r;
        rd_val[sps_pkg::ST_SRCOK_BIT] = wake_source_ok;
      end
      default: rd_val = 32'h00000000;
    endcase
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  sequence s_accept_zero;
    accept && (wpc_new == 3'h0) && !rst_i;
  endsequence

  sequence s_enter_sleep;
    (state_r != sps_pkg::ST_SLEEP) ##1 (state_r == sps_pkg::ST_SLEEP);
  endsequence

  a_pin_sleep_route: assert property ($past(sel_r) == sps_pkg::SEL_SLEEP
    |-> switch_irq2_pin_oe_o == ($past(state_r) != sps_pkg::ST_SLEEP))
    else $error("switch pin does not follow the sleep state");
  a_sleep_indicate: assert property (
    (sel_r == sps_pkg::SEL_SLEEP && !lowres_r && state_r == sps_pkg::ST_SLEEP)
    |=> !switch_irq2_pin_oe_o && !low_res_switch_o)
    else $error("sleep indication not released high");
  a_static_level: assert property ((sel_r == sps_pkg::SEL_STATIC)
    |=> switch_irq2_pin_oe_o == !$past(level_r))
    else $error("static level not driven on switch pin");
  a_zero_skip: assert property (s_accept_zero |=> state_r == sps_pkg::ST_SLEEP)
    else $error("zero wait count did not go straight to sleep");
  a_wait_hold: assert property ((state_r == sps_pkg::ST_WAIT && wcnt_r != 3'h0)
    |=> state_r != sps_pkg::ST_SLEEP)
    else $error("sleep entered before the wait count ran out");
  a_wake_return: assert property ((state_r != sps_pkg::ST_RUN && wake_event && pv_r)
    |=> state_r == sps_pkg::ST_RUN ##1 power_switch_signal_o && !sleep_request_r)
    else $error("wake did not return to run with power");
  a_slept_set: assert property (s_enter_sleep |-> slept_flag_r)
    else $error("slept flag not set on sleep entry");
  a_request_guard: assert property ($rose(sleep_request_r)
    |-> $past(wr_ctrl && wake_source_ok && !wake_event))
    else $error("sleep request raised without a guarded write");
  a_power_hold: assert property (!pv_r |=> state_r == sps_pkg::ST_RUN
    && !sleep_request_r && wcnt_r == 3'h0)
    else $error("machine not held in run without valid power");
  a_level_lock: assert property ((wr_pin && lock_r && !level_r) |=> !level_r)
    else $error("static level raised while locked");
  a_reset_extend: assert property ((state_r == sps_pkg::ST_SLEEP && rsten_r
    && wake_event && pv_r) |=> ##1 host_reset_out_o [*2])
    else $error("host reset released without extension");

endmodule

// ### src/sps_pkg.sv
// Purpose: Shared constants and types of the sleep power sequencer.
// Assumes: 125 MHz system clock, 32-bit AHB-Lite register access.
// Notes: Register offsets are byte addresses of aligned words.
package sps_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [11:0] SLEEP_CTRL_OFS = 12'h000;
  localparam logic [11:0] PIN_CTRL_OFS = 12'h004;
  localparam logic [11:0] WAKE_CFG_OFS = 12'h008;
  localparam logic [11:0] STATUS_OFS = 12'h00C;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int SC_WPC_LSB = 0;
  localparam int WPC_W = 3;
  localparam int SC_SLEPT_BIT = 4;
  localparam int SC_GATE_BIT = 5;
  localparam int SC_RSTEN_BIT = 6;
  localparam int SC_REQ_BIT = 7;
  localparam int PC_SEL_LSB = 0;
  localparam int SEL_W = 3;
  localparam int PC_LOWRES_BIT = 3;
  localparam int PC_LEVEL_BIT = 4;
  localparam int PC_LOCK_BIT = 5;
  localparam int WC_EN_LSB = 0;
  localparam int NUM_SRC = 8;
  localparam int WC_RUN_BIT = 8;
  localparam int WC_HALT_BIT = 9;
  localparam int WC_WDRST_BIT = 10;
  localparam int WC_MULT_LSB = 11;
  localparam int MULT_W = 5;
  localparam int ST_STATE_LSB = 8;
  localparam int ST_EXPIRED_BIT = 10;
  localparam int ST_PVALID_BIT = 11;
  localparam int ST_SRCOK_BIT = 12;

  // Wake source index within the enable field and the request input.
  localparam int SRC_ALARM = 0;
  localparam int SRC_COUNTDOWN = 1;
  localparam int SRC_WDOG = 2;
  localparam int SRC_EXT1 = 3;
  localparam int SRC_EXT2 = 4;
  localparam int SRC_BATLOW = 5;
  localparam int SRC_ACAL = 6;
  localparam int SRC_OSC = 7;

  // ************************************************************
  // Reset values and encodings
  // ************************************************************
  localparam logic [2:0] SEL_STATIC = 3'h7;
  localparam logic [2:0] SEL_SLEEP = 3'h6;
  localparam logic [2:0] WPC_RST = 3'h0;
  localparam logic [7:0] EN_RST = 8'h00;
  localparam logic LOCK_RST = 1'b1;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_PERIOD_NS = 8000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [3:0] RST_EXT_TICKS = 4'h8;

  typedef enum logic [1:0]
  {
    ST_RUN = 2'b00,
    ST_WAIT = 2'b01,
    ST_SLEEP = 2'b10
  } sps_state_type;

endpackage

// ### src/sps_tick_div.sv
// Purpose: Divides the system clock down to the sleep timebase tick.
// Assumes: CYCLES is at least 2.
// Notes: A clear restarts the period so the next tick is a full period away.
`timescale 1ns/10ps
module sps_tick_div #(
  parameter int CYCLES = sps_pkg::TICK_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic clear_i,
  output logic tick_o
);

  localparam int CW = $clog2(CYCLES);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count_r;

  always_ff @(posedge clock_i)
  begin
    if (rst_i || clear_i)
    begin
      count_r <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= (count_r == LAST);
      if (count_r == LAST)
        count_r <= '0;
      else
        count_r <= count_r + CW'(1);
    end
  end

endmodule

// ### testbench/sps_host_model.sv
// Purpose: Host seen from the switch pin, with its ground switched by the pin.
// Assumes: The pin has a pull-up on the host side of the switch.
// Notes: The host runs only while the pin is low and its reset is released.
`timescale 1ns/10ps
module sps_host_model (
  input wire logic pin_oe_i,
  input wire logic pin_drv_i,
  input wire logic host_reset_i,
  output logic pin_level_o,
  output logic host_run_o
);
  // A released pin goes to the pull-up level, not to the last driven value.
  assign pin_level_o = pin_oe_i ? pin_drv_i : 1'b1;
  // A host without power issues nothing after its request write.
  // Only the switch pin and the host reset reach it, so no other pin leaks.
  assign host_run_o = !pin_level_o && !host_reset_i;
endmodule

// ### testbench/test_sleep_power_sequencer.sv
// Purpose: Self-checking bench of the sleep sequencer over AHB-Lite.
// Assumes: One slave, so the bus hready is the slave's hreadyout.
// Notes: A short tick period keeps the sleep waits brief.
`timescale 1ns/10ps
module test_sleep_power_sequencer;
  localparam int TC = 10;
  localparam logic [11:0] SC = sps_pkg::SLEEP_CTRL_OFS;
  localparam logic [11:0] PC = sps_pkg::PIN_CTRL_OFS;
  localparam logic [11:0] WC = sps_pkg::WAKE_CFG_OFS;
  localparam logic [11:0] ST = sps_pkg::STATUS_OFS;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic pv = 1'b1;
  logic [7:0] irq = 8'h00;
  logic hready, hresp, power_switch_signal, hrst, pin_o, pin_oe, lowres, gate, pin, hrun;
  logic [31:0] hrdata;
  logic [31:0] cfg_t [9] = '{32'h0, 32'h201, 32'h2, 32'hC00, 32'h1, 32'h102, 32'h8, 32'h10, 32'h804};
  int bit_t [9] = '{0, 0, 0, 0, 0, 1, 3, 4, 2};
  int n_mismatch = 0;
  int checks = 0;
  wire [4:0] outs = {power_switch_signal, hrst, pin, lowres, gate};
  sps_sleep_seq #(.TICK_CYCLES(TC)) dut_u (.clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .power_valid_i(pv), .irq_req_i(irq),
    .power_switch_signal_o(power_switch_signal), .host_reset_out_o(hrst), .switch_irq2_pin_o(pin_o),
    .switch_irq2_pin_oe_o(pin_oe), .low_res_switch_o(lowres), .bus_gate_o(gate));
  sps_host_model host_u (.pin_oe_i(pin_oe), .pin_drv_i(pin_o), .host_reset_i(hrst), .pin_level_o(pin),
    .host_run_o(hrun));

  // ************************************************************
  // Bus and compare tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock_i);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= sps_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clock_i); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock_i); while (hready !== 1'b1);
    q = hrdata;
    #1;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q & m);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic set_irq(input logic [7:0] v);
    @(posedge clock_i);
    irq <= v;
  endtask

  task automatic close_out();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ************************************************************
  // Tests
  // ************************************************************
  initial
  begin
    forever #4 clock_i = ~clock_i;
  end

  initial
  begin
    #240000;
    n_mismatch++;
    close_out();
  end

  initial
  begin
    int t0;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    tick(3);
    chk("outputs", 32'h10, {27'h0, outs});
    rc("pin_ctrl", PC, 32'h3F, 32'h27);
    rc("wake_cfg", WC, 32'hFFFF, 32'h0);
    rc("sleep_ctrl", SC, 32'hFF, 32'h0);
    wr(12'h010, 32'hFFFF_FFFF);
    rc("unmapped", 12'h010, 32'hFFFF_FFFF, 32'h0);
    chk("hresp", 32'h0, {31'h0, hresp});
    wr(PC, 32'h37);
    rc("pin_ctrl", PC, 32'h3F, 32'h27);
    wr(PC, 32'h07);
    wr(PC, 32'h17);
    tick(2);
    chk("outputs", 32'h14, {27'h0, outs});
    wr(PC, 32'h07);
    wr(PC, 32'h0E);
    tick(2);
    chk("outputs", 32'h12, {27'h0, outs});
    // Guard table: first four configurations leave no usable wake source.
    for (int i = 0; i < 9; i++)
    begin
      wr(WC, cfg_t[i]);
      wr(SC, 32'h80);
      rc("request", SC, 32'h80, (i >= 4) ? 32'h80 : 32'h0);
      rc("state", ST, 32'h300, (i >= 4) ? 32'h200 : 32'h0);
      rc("slept", SC, 32'h10, (i >= 4) ? 32'h10 : 32'h0);
      chk("outputs", (i >= 4) ? 32'h06 : 32'h12, {27'h0, outs});
      chk("host_run", (i >= 4) ? 32'h0 : 32'h1, {31'h0, hrun});
      if (i >= 4)
      begin
        set_irq(8'h01 << bit_t[i]);
        tick(3);
        chk("outputs", 32'h12, {27'h0, outs});
        rc("state", ST, 32'h300, 32'h0);
        rc("slept", SC, 32'h90, 32'h10);
        set_irq(8'h00);
      end
    end
    // Oscillator-failure source pending blocks the request as well.
    wr(WC, 32'h81);
    set_irq(8'h80);
    wr(SC, 32'h80);
    rc("request", SC, 32'h80, 32'h0);
    set_irq(8'h00);
    wr(SC, 32'h83);
    t0 = $time;
    rc("wait_ctrl", SC, 32'h90, 32'h80);
    rc("state", ST, 32'h300, 32'h100);
    chk("outputs", 32'h12, {27'h0, outs});
    for (int c = 0; c < 60 && power_switch_signal === 1'b1; c++)
      tick(1);
    t0 = ($time - t0) / 8;
    chk("wait_span", 32'h1, {31'h0, t0 >= 3 * TC && t0 <= 4 * TC + 2});
    rc("request", SC, 32'h80, 32'h80);
    rc("state", ST, 32'h300, 32'h200);
    set_irq(8'h01);
    tick(3);
    set_irq(8'h00);
    wr(SC, 32'h87);
    tick(20);
    set_irq(8'h01);
    tick(3);
    rc("request", SC, 32'h80, 32'h0);
    set_irq(8'h00);
    tick(9 * TC);
    chk("outputs", 32'h12, {27'h0, outs});
    wr(SC, 32'h87);
    tick(5);
    @(posedge clock_i);
    pv <= 1'b0;
    tick(5);
    rc("state", ST, 32'h300, 32'h0);
    rc("request", SC, 32'h80, 32'h0);
    @(posedge clock_i);
    pv <= 1'b1;
    tick(3);
    wr(PC, 32'h06);
    wr(SC, 32'hE0);
    tick(2);
    chk("outputs", 32'h0D, {27'h0, outs});
    set_irq(8'h01);
    tick(3);
    chk("outputs", 32'h18, {27'h0, outs});
    tick(6 * TC);
    chk("outputs", 32'h18, {27'h0, outs});
    tick(3 * TC);
    chk("outputs", 32'h10, {27'h0, outs});
    chk("host_run", 32'h1, {31'h0, hrun});
    set_irq(8'h00);
    close_out();
  end
endmodule
